// ### sud_defs.svh
`ifndef SUD_DEFS_SVH
`define SUD_DEFS_SVH

// ==========================================================
// instruction word fields
`define SUD_F_ADJUST_INDEX_B_DEST_INDEX      2:0
`define SUD_F_LOAD_A     18:0
`define SUD_F_HIGH_HALF_IMM     15:0
`define SUD_F_FACT_A    9:1
`define SUD_F_FACT_B    18:10
`define SUD_B_SIGN_B    1
`define SUD_B_SIGN_A    2
`define SUD_F_BYTE_IMM      10:3
`define SUD_F_IMM13     15:3
`define SUD_F_BITOP     6:3
`define SUD_F_OTHER_FILE_SEL     7:3
`define SUD_F_ADJ_IDX   4:3
`define SUD_F_ADJ_SEL   8:5
`define SUD_B_RND       8
`define SUD_F_SECOND_SRC_INDEX      13:9
`define SUD_F_FIRST_SRC_INDEX      18:14
`define SUD_F_DST       23:19
`define SUD_F_VEC_ADJUST_INDEX_B_INDEX     20:19
`define SUD_B_VCHALF    21
`define SUD_F_VCXF_LO   23:22
`define SUD_B_VCXF_HI   0
`define SUD_F_OPC       31:24
`define SUD_B_OPC_TOP   7
`define SUD_B_OPC_IMM   5
`define SUD_B_OPC_UNS   4

// ==========================================================
// opcodes and constants
`define SUD_OPC_MOVI    8'h65
`define SUD_OPC_SETHI   8'h75
`define SUD_OPC_TOFILE  8'h6A
`define SUD_OPC_FRFILE  8'h6B
`define SUD_OPC_VEC     8'h24
`define SUD_OPC_VECMS   8'h45
`define SUD_OPC_BVEC    8'h0F
`define SUD_OPC_BVMAD   8'h04
`define SUD_OPC_BVMADS  8'h05
`define SUD_OPC_BITOP   8'h42
`define SUD_OPC_NOP     8'h4F
`define SUD_ADJUST_INDEX_B_DEST_INDEX_LIMIT  3'h4
`define SUD_SEL_ADD     4'h4
`define SUD_ZERO_REG    5'h1F
`define SUD_SHIFT_BAD   6'h20
`define SUD_RF_CONDS    5'h0D
`define SUD_RF_ALIAS    5'h12
`define SUD_RF_ALIASED  5'h02
`define SUD_XF_PAIR     3'h7

// ==========================================================
// register map (byte offsets)
`define SUD_REG_INSN    8'h00
`define SUD_REG_STATUS  8'h04
`define SUD_REG_ADJUST_INDEX_B    8'h08
`define SUD_REG_S2V     8'h0C
`define SUD_REG_FACT    8'h10
`define SUD_REG_FIELDS  8'h14
`define SUD_GPR_WIN     1'b1

`endif

// ### sud_pkg.sv
package sud_pkg;
    typedef enum logic [2:0] {
        SUD_OP_NONE,
        SUD_OP_ARITH,
        SUD_OP_MOVI,
        SUD_OP_SETHI,
        SUD_OP_TOFILE,
        SUD_OP_FRFILE,
        SUD_OP_S2V
    } sud_op_t;

    typedef enum logic [0:0] {
        SUD_ST_IDLE,
        SUD_ST_EXEC
    } sud_state_t;
endpackage

// ### sud_core.sv
`timescale 1ns/100ps
`include "sud_defs.svh"

module sud_core (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] vector_adjust_index_b_reg0,
    input  wire logic [31:0] vector_adjust_index_b_reg1,
    input  wire logic [31:0] vector_adjust_index_b_reg2,
    input  wire logic [31:0] vector_adjust_index_b_reg3,
    input  wire logic [31:0] ofile_rdata,
    output logic             ofile_wr,
    output logic      [4:0]  ofile_sel,
    output logic      [4:0]  ofile_idx,
    output logic      [31:0] ofile_wdata,
    output logic             s2v_valid,
    output logic      [15:0] s2v_mask,
    output logic      [9:0]  s2v_factor_a,
    output logic      [9:0]  s2v_factor_b
);
    import sud_pkg::*;

    // ==========================================================
    // helper functions
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // source bit of the 32-bit {pair, half} word for output bit idx
    function automatic logic [4:0] xf_src(input logic [2:0] mode, input logic [3:0] idx);
        logic [4:0] s;
        s = {1'b0, idx};
        case (mode)
            3'h0: s = {1'b0, idx};
            3'h1: s = {1'b0, idx[3:2], 2'b10};
            3'h2: s = {1'b0, idx[3], 2'b10, idx[0]};
            3'h3: s = {1'b0, idx[3:2], idx[1] & ~idx[0], 1'b0};
            3'h4: s = {1'b0, idx[3:2], idx[1] & idx[0], 1'b1};
            3'h5: s = {1'b0, idx[3:1], 1'b0};
            3'h6: s = {1'b0, idx[3:2], 2'b01};
            default: s = {idx, 1'b0};
        endcase
        return s;
    endfunction

    function automatic logic known_file(input logic [4:0] sel, input logic wr);
        logic k;
        k = 1'b0;
        case (sel)
            5'h00, 5'h01, 5'h02, 5'h03: k = 1'b1;
            5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C: k = 1'b1;
            5'h14, 5'h15, 5'h16, 5'h17, 5'h18: k = 1'b1;
            5'h0D: k = ~wr;
            5'h12: k = wr;
            default: k = 1'b0;
        endcase
        return k;
    endfunction

    // ==========================================================
    // state
    sud_state_t  state_r;
    logic [31:0] insn_r;
    logic [31:0] gpr_r [0:30];
    logic [7:0]  adjust_index_b_r [0:3];
    logic        wait_r;
    logic [31:0] rdata_r;
    logic [11:0] status_r;
    logic        ofile_wr_r;
    logic [4:0]  ofile_sel_r;
    logic [4:0]  ofile_idx_r;
    logic [31:0] ofile_wdata_r;
    logic        s2v_valid_r;
    logic [15:0] s2v_mask_r;
    logic [9:0]  fact_a_r;
    logic [9:0]  fact_b_r;

    // ==========================================================
    // field decode
    wire [7:0]  opc       = insn_r[`SUD_F_OPC];
    wire        scalar_op = ~opc[`SUD_B_OPC_TOP];
    wire [2:0]  adjust_index_b_dest_index = insn_r[`SUD_F_ADJUST_INDEX_B_DEST_INDEX];
    wire        adjust_index_b_dest_index_ok   = adjust_index_b_dest_index < `SUD_ADJUST_INDEX_B_DEST_INDEX_LIMIT;
    wire [4:0]  first_src_index  = insn_r[`SUD_F_FIRST_SRC_INDEX];
    wire [4:0]  second_src_index = insn_r[`SUD_F_SECOND_SRC_INDEX];
    wire [4:0]  dest_index       = insn_r[`SUD_F_DST];
    wire [1:0]  adjust_index_b   = insn_r[`SUD_F_ADJ_IDX];
    wire [3:0]  adjust_bit_sel   = insn_r[`SUD_F_ADJ_SEL];
    wire [31:0] load_a = {{13{insn_r[18]}}, insn_r[`SUD_F_LOAD_A]};
    wire [15:0] high_half_imm = insn_r[`SUD_F_HIGH_HALF_IMM];
    wire [7:0]  byte_imm  = insn_r[`SUD_F_BYTE_IMM];
    wire [31:0] word_imm13 = {{19{insn_r[15]}}, insn_r[`SUD_F_IMM13]};
    wire [3:0]  bitop_sel = insn_r[`SUD_F_BITOP];
    wire [4:0]  other_file_sel = insn_r[`SUD_F_OTHER_FILE_SEL];
    wire [1:0]  vec_adjust_index_b_index = insn_r[`SUD_F_VEC_ADJUST_INDEX_B_INDEX];
    wire        vec_adjust_index_b_half_sel = insn_r[`SUD_B_VCHALF];
    wire [2:0]  vec_adjust_index_b_transform = {insn_r[`SUD_B_VCXF_HI], insn_r[`SUD_F_VCXF_LO]};
    wire [9:0]  vec_factor_a = {insn_r[9], insn_r[`SUD_F_FACT_A]};
    wire [9:0]  vec_factor_b = {insn_r[18], insn_r[`SUD_F_FACT_B]};
    wire        mul_src_b_signed = insn_r[`SUD_B_SIGN_B];
    wire        mul_src_a_signed = insn_r[`SUD_B_SIGN_A];
    wire        mul_round_sel    = insn_r[`SUD_B_RND];

    // ==========================================================
    // source adjustment
    wire [7:0]  adj_adjust_index_b = adjust_index_b_r[adjust_index_b];
    wire        adj_bit  = (adjust_bit_sel[3]) ? 1'b0 : adj_adjust_index_b[adjust_bit_sel[2:0]];
    wire [1:0]  adj_sum  = second_src_index[1:0] + adj_adjust_index_b[5:4];
    wire [4:0]  adjusted_second_src = (adjust_bit_sel == `SUD_SEL_ADD) ?
                {second_src_index[4:2], adj_sum} :
                {second_src_index[4:1], second_src_index[0] ^ adj_bit};

    // r31 reads as zero
    wire [31:0] s1 = (first_src_index == `SUD_ZERO_REG) ? 32'h0 : gpr_r[first_src_index];
    wire [31:0] s2_reg = (adjusted_second_src == `SUD_ZERO_REG) ? 32'h0 :
                         gpr_r[adjusted_second_src];
    wire [31:0] dst_old = (dest_index == `SUD_ZERO_REG) ? 32'h0 : gpr_r[dest_index];
    wire [31:0] s2 = opc[`SUD_B_OPC_IMM] ? word_imm13 : s2_reg;

    // ==========================================================
    // opcode class
    wire is_file_mov = (opc == `SUD_OPC_TOFILE) || (opc == `SUD_OPC_FRFILE);
    wire arith_nib = (opc[3:0] == 4'h1) || (opc[3:0] >= 4'h8 && opc[3:0] <= 4'hE);
    wire is_arith = scalar_op && (opc[6] == 1'b1) && arith_nib && !is_file_mov;
    wire is_s2v = (opc == `SUD_OPC_VEC) || (opc == `SUD_OPC_VECMS) ||
                  (opc == `SUD_OPC_BVEC) || (opc == `SUD_OPC_BVMAD) ||
                  (opc == `SUD_OPC_BVMADS);
    sud_op_t op_class;
    assign op_class = !scalar_op              ? SUD_OP_NONE   :
                      (opc == `SUD_OPC_MOVI)  ? SUD_OP_MOVI   :
                      (opc == `SUD_OPC_SETHI) ? SUD_OP_SETHI  :
                      (opc == `SUD_OPC_TOFILE) ? SUD_OP_TOFILE :
                      (opc == `SUD_OPC_FRFILE) ? SUD_OP_FRFILE :
                      is_arith                ? SUD_OP_ARITH  :
                      is_s2v                  ? SUD_OP_S2V    : SUD_OP_NONE;

    // ==========================================================
    // arithmetic group
    wire signed [31:0] prod = $signed(s1[15:0]) * $signed(s2[15:0]);
    wire        s_lt = $signed(s1) < $signed(s2);
    wire [5:0]  amt_raw = s2[5:0];
    wire [5:0]  amt = (amt_raw == `SUD_SHIFT_BAD) ? 6'h00 : amt_raw;
    wire [5:0]  amt_mag = amt[5] ? 6'(-amt) : amt;
    wire        logical = opc[`SUD_B_OPC_UNS];
    wire [31:0] sh_right = logical ? (s1 >> amt_mag) :
                           32'($signed(s1) >>> amt_mag);
    wire [31:0] sh_res = amt[5] ? (s1 << amt_mag) : sh_right;
    logic [31:0] ar_res;
    always_comb begin
        case (opc[3:0])
            4'h1:    ar_res = 32'(prod);
            4'h8:    ar_res = s_lt ? s1 : s2;
            4'h9:    ar_res = s_lt ? s2 : s1;
            4'hA:    ar_res = s1[31] ? 32'(-s1) : s1;
            4'hB:    ar_res = 32'(-s1);
            4'hC:    ar_res = s1 + s2;
            4'hD:    ar_res = s1 - s2;
            4'hE:    ar_res = sh_res;
            default: ar_res = 32'h0;
        endcase
    end
    wire [7:0] ar_flags = {2'b00, ar_res[21], ar_res[20], ar_res[20] ^ s1[20],
                           ar_res[19], ar_res == 32'h0, ar_res[31]};

    // ==========================================================
    // mask transform for the scalar-to-vector bus
    logic [31:0] vc_sel;
    logic [31:0] vc_pair;
    always_comb begin
        case (vec_adjust_index_b_index)
            2'h0:    vc_sel = vector_adjust_index_b_reg0;
            2'h1:    vc_sel = vector_adjust_index_b_reg1;
            2'h2:    vc_sel = vector_adjust_index_b_reg2;
            default: vc_sel = vector_adjust_index_b_reg3;
        endcase
        vc_pair = vec_adjust_index_b_index[1] ? vector_adjust_index_b_reg3 : vector_adjust_index_b_reg1;
    end
    wire [15:0] half_a = vec_adjust_index_b_half_sel ? vc_sel[31:16] : vc_sel[15:0];
    wire [15:0] half_b = vec_adjust_index_b_half_sel ? vc_pair[31:16] : vc_pair[15:0];
    wire [31:0] xf_in  = (vec_adjust_index_b_transform == `SUD_XF_PAIR) ?
                         {half_b, half_a} : {16'h0, half_a};
    wire [15:0] xf_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_xf
            assign xf_mask[gi] = xf_in[xf_src(vec_adjust_index_b_transform, 4'(gi))];
        end
    endgenerate

    // ==========================================================
    // execute: next values
    wire [4:0] ofile_eff = (other_file_sel == `SUD_RF_ALIAS) ? `SUD_RF_ALIASED :
                           other_file_sel;
    wire [31:0] adjust_index_b_rd = (first_src_index[4:2] != 3'h0) ? 32'h0 :
                          {24'h0, adjust_index_b_r[first_src_index[1:0]]};
    logic        dst_we;
    logic [31:0] dst_val;
    logic        c_we;
    logic [7:0]  c_val;
    logic        ofw_nxt;
    logic        unk_nxt;
    always_comb begin
        dst_we  = 1'b0;
        dst_val = 32'h0;
        c_we    = 1'b0;
        c_val   = 8'h00;
        ofw_nxt = 1'b0;
        unk_nxt = 1'b0;
        case (op_class)
            SUD_OP_ARITH: begin
                dst_we  = 1'b1;
                dst_val = ar_res;
                c_we    = adjust_index_b_dest_index_ok;
                c_val   = ar_flags;
            end
            SUD_OP_MOVI: begin
                dst_we  = 1'b1;
                dst_val = load_a;
            end
            SUD_OP_SETHI: begin
                dst_we  = 1'b1;
                dst_val = {high_half_imm, dst_old[15:0]};
            end
            SUD_OP_TOFILE: begin
                ofw_nxt = known_file(other_file_sel, 1'b1);
                unk_nxt = ~ofw_nxt;
                c_we    = adjust_index_b_dest_index_ok;
            end
            SUD_OP_FRFILE: begin
                dst_we  = known_file(other_file_sel, 1'b0);
                unk_nxt = ~dst_we;
                dst_val = (other_file_sel == `SUD_RF_CONDS) ? adjust_index_b_rd : ofile_rdata;
                c_we    = adjust_index_b_dest_index_ok;
            end
            default: begin
                dst_we = 1'b0;
            end
        endcase
        if (dest_index == `SUD_ZERO_REG) begin
            dst_we = 1'b0;
        end
    end

    // ==========================================================
    // Avalon slave decode
    wire        req      = avs_read | avs_write;
    // one wait cycle; held off while an instruction executes
    wire        accept   = req && wait_r && (state_r == SUD_ST_IDLE);
    wire        done     = req && !wait_r;
    wire        wr_done  = done && avs_write;
    wire        gpr_hit  = avs_address[7] == `SUD_GPR_WIN;
    wire [4:0]  gpr_a    = avs_address[6:2];
    wire        insn_wr  = wr_done && (avs_address == `SUD_REG_INSN);
    wire        adjust_index_b_wr  = wr_done && (avs_address == `SUD_REG_ADJUST_INDEX_B);
    wire [31:0] adjust_index_b_word = {adjust_index_b_r[3], adjust_index_b_r[2], adjust_index_b_r[1], adjust_index_b_r[0]};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (gpr_hit) begin
            rd_mux = (gpr_a == `SUD_ZERO_REG) ? 32'h0 : gpr_r[gpr_a];
        end else begin
            case (avs_address)
                `SUD_REG_INSN:   rd_mux = insn_r;
                `SUD_REG_STATUS: rd_mux = {20'h0, status_r};
                `SUD_REG_ADJUST_INDEX_B:   rd_mux = adjust_index_b_word;
                `SUD_REG_S2V:    rd_mux = {15'h0, s2v_valid_r, s2v_mask_r};
                `SUD_REG_FACT:   rd_mux = {6'h0, fact_b_r, 6'h0, fact_a_r};
                `SUD_REG_FIELDS: rd_mux = {12'h0, mul_round_sel, mul_src_a_signed,
                                           mul_src_b_signed, other_file_sel,
                                           bitop_sel, byte_imm};
                default:         rd_mux = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // sequencing and bus answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= SUD_ST_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
            insn_r  <= 32'h0;
        end else begin
            wait_r  <= ~accept;
            if (accept) begin
                rdata_r <= rd_mux;
            end
            if (insn_wr) begin
                insn_r  <= avs_writedata;
                state_r <= SUD_ST_EXEC;
            end else begin
                state_r <= SUD_ST_IDLE;
            end
        end
    end

    // ==========================================================
    // scalar and condition registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 31; i++) begin
                gpr_r[i] <= 32'h0;
            end
            for (int j = 0; j < 4; j++) begin
                adjust_index_b_r[j] <= 8'h00;
            end
        end else if (state_r == SUD_ST_EXEC) begin
            if (dst_we) begin
                gpr_r[dest_index] <= dst_val;
            end
            if (c_we) begin
                adjust_index_b_r[adjust_index_b_dest_index[1:0]] <= c_val;
            end
        end else if (wr_done && gpr_hit && gpr_a != `SUD_ZERO_REG) begin
            gpr_r[gpr_a] <= be_merge(gpr_r[gpr_a], avs_writedata, avs_byteenable);
        end else if (adjust_index_b_wr) begin
            for (int j = 0; j < 4; j++) begin
                if (avs_byteenable[j]) begin
                    adjust_index_b_r[j] <= avs_writedata[j*8 +: 8];
                end
            end
        end
    end

    // ==========================================================
    // outward strobes, s2v bus and status
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ofile_wr_r    <= 1'b0;
            ofile_sel_r   <= 5'h00;
            ofile_idx_r   <= 5'h00;
            ofile_wdata_r <= 32'h0;
            s2v_valid_r   <= 1'b0;
            s2v_mask_r    <= 16'h0;
            fact_a_r      <= 10'h0;
            fact_b_r      <= 10'h0;
            status_r      <= 12'h0;
        end else begin
            ofile_wr_r  <= (state_r == SUD_ST_EXEC) && ofw_nxt;
            s2v_valid_r <= 1'b0;
            if (insn_wr) begin
                // read side of a from-file move looks at first source index
                ofile_sel_r <= avs_writedata[`SUD_F_OTHER_FILE_SEL];
                ofile_idx_r <= avs_writedata[`SUD_F_FIRST_SRC_INDEX];
            end
            if (state_r == SUD_ST_EXEC) begin
                if (op_class == SUD_OP_TOFILE) begin
                    ofile_sel_r   <= ofile_eff;
                    ofile_idx_r   <= dest_index;
                    ofile_wdata_r <= s1;
                end
                if (op_class == SUD_OP_S2V) begin
                    s2v_valid_r <= 1'b1;
                    s2v_mask_r  <= xf_mask;
                    fact_a_r    <= vec_factor_a;
                    fact_b_r    <= vec_factor_b;
                end
                status_r <= {unk_nxt, op_class == SUD_OP_S2V, c_we,
                             op_class == SUD_OP_ARITH, opc};
            end
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign ofile_wr        = ofile_wr_r;
    assign ofile_sel       = ofile_sel_r;
    assign ofile_idx       = ofile_idx_r;
    assign ofile_wdata     = ofile_wdata_r;
    assign s2v_valid       = s2v_valid_r;
    assign s2v_mask        = s2v_mask_r;
    assign s2v_factor_a    = fact_a_r;
    assign s2v_factor_b    = fact_b_r;
endmodule

// ### sud_asserts.sv
`timescale 1ns/100ps
// ======
// port checks
module sud_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        ofile_wr,
    input wire logic [4:0]  ofile_sel,
    input wire logic        s2v_valid,
    input wire logic [15:0] s2v_mask,
    input wire logic [9:0]  s2v_factor_a,
    input wire logic [9:0]  s2v_factor_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_no_req_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");
    a_ofile_pulse: assert property (ofile_wr |=> !ofile_wr)
        else $error("file write longer than one cycle");
    a_s2v_pulse: assert property (s2v_valid |=> !s2v_valid)
        else $error("s2v valid longer than one cycle");
    a_mask_held: assert property (!$rose(s2v_valid) |-> $stable(s2v_mask))
        else $error("mask moved without emission");
    a_fact_held: assert property (!$rose(s2v_valid) |-> $stable({s2v_factor_a, s2v_factor_b}))
        else $error("factors moved without emission");
    a_fact_sext: assert property (s2v_factor_a[9] == s2v_factor_a[8]
        && s2v_factor_b[9] == s2v_factor_b[8]) else $error("factor not sign extended");
    a_file_known: assert property (
        ofile_wr |-> ofile_sel inside {[0:3], [8:12], 18, [20:24]})
        else $error("write to unknown file");
endmodule

bind sud_core sud_asserts i_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ofile_wr(ofile_wr),
    .ofile_sel(ofile_sel), .s2v_valid(s2v_valid), .s2v_mask(s2v_mask),
    .s2v_factor_a(s2v_factor_a), .s2v_factor_b(s2v_factor_b));

// ### sud_ofile_model.sv
`timescale 1ns/100ps
// ======
// other register files
module sud_ofile_model (
    input wire logic        clk,
    input wire logic        ofile_wr,
    input wire logic [4:0]  ofile_sel,
    input wire logic [4:0]  ofile_idx,
    input wire logic [31:0] ofile_wdata,
    output logic     [31:0] ofile_rdata
);
    logic [31:0] mem [32][32];
    // nonzero junk, so a read from an unknown file would show in the target
    initial foreach (mem[i, j]) mem[i][j] = 32'hA5000000 + 32'(i * 64 + j);
    wire [4:0] wsel = (ofile_sel == 5'h12) ? 5'h02 : ofile_sel;
    always @(posedge clk) if (ofile_wr) mem[wsel][ofile_idx] <= ofile_wdata;
    assign ofile_rdata = mem[ofile_sel][ofile_idx];
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, rnd = 32'hE4A1, x, y, m, e;
    logic [31:0] vc [4] = '{default: 32'h0};
    logic [31:0] avs_readdata, ofile_rdata, ofile_wdata;
    logic [4:0]  ofile_sel, ofile_idx;
    logic        avs_waitrequest, ofile_wr, s2v_valid;
    logic [15:0] s2v_mask;
    logic [9:0]  s2v_factor_a, s2v_factor_b;
    logic [35:0] rd_q [$], s2v_q [$];
    int          mismatches = 0, compares = 0;
    always #5 clk = ~clk;
    sud_core i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .vector_adjust_index_b_reg0(vc[0]), .vector_adjust_index_b_reg1(vc[1]), .vector_adjust_index_b_reg2(vc[2]),
        .vector_adjust_index_b_reg3(vc[3]), .ofile_rdata(ofile_rdata), .ofile_wr(ofile_wr),
        .ofile_sel(ofile_sel), .ofile_idx(ofile_idx), .ofile_wdata(ofile_wdata),
        .s2v_valid(s2v_valid), .s2v_mask(s2v_mask), .s2v_factor_a(s2v_factor_a),
        .s2v_factor_b(s2v_factor_b));
    sud_ofile_model i_far (.clk(clk), .ofile_wr(ofile_wr), .ofile_sel(ofile_sel),
        .ofile_idx(ofile_idx), .ofile_wdata(ofile_wdata), .ofile_rdata(ofile_rdata));
    // ======
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] flags(input logic [31:0] r, input logic [31:0] s1);
        return {2'b00, r[21], r[20], r[20] ^ s1[20], r[19], r == 32'h0, r[31]};
    endfunction
    function automatic logic [15:0] xf(input logic [2:0] md, input logic [15:0] h, h2);
        logic [3:0] k, t;
        logic [15:0] r;
        logic [31:0] w;
        w = {h2, h};
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            case (md)
                3'h1: t = {k[3:2], 2'b10};
                3'h2: t = {k[3], 2'b10, k[0]};
                3'h3: t = {k[3:2], k[1:0] == 2'b10, 1'b0};
                3'h4: t = {k[3:2], &k[1:0], 1'b1};
                3'h5: t = {k[3:1], 1'b0};
                3'h6: t = {k[3:2], 2'b01};
                default: t = k;
            endcase
            r[i] = (md == 3'h7) ? w[2 * i] : h[t];
        end
        return r;
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // only the watchdog ends a wait that never gets its answer
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        rd_q.push_back({4'h0, ex});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic chk(input logic [35:0] ex, input logic [35:0] got);
        compares++;
        if (got !== ex) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, ex);
        end
    endtask
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) chk(rd_q.pop_front(), {4'h0, avs_readdata});
        if (s2v_valid === 1'b1) chk(s2v_q.pop_front(), {s2v_mask, s2v_factor_a, s2v_factor_b});
    end
    task automatic print_verdict;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #300000;
        mismatches++;
        print_verdict;
    end
    // ======
    // scenarios
    initial begin : main
        logic [2:0] md;
        logic [1:0] ix;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rnd = lfsr(rnd);
        x = {{13{rnd[18]}}, rnd[18:0]};
        bus(1'b1, 8'h00, {8'h65, 5'd2, rnd[18:0]});
        rnd = lfsr(rnd);
        bus(1'b1, 8'h00, {8'h65, 5'd3, rnd[18:0]});
        bus(1'b1, 8'h00, {8'h75, 5'd3, 3'h0, rnd[31:16]});
        y = {rnd[31:16], rnd[15:0]};
        rd(8'h88, x);
        rd(8'h8C, y);
        bus(1'b1, 8'h08, 32'h000001FF);
        bus(1'b1, 8'h00, {8'h41, 5'd4, 5'd2, 5'd2, 4'h0, 2'd1, 3'h7});
        m = 32'($signed(x[15:0]) * $signed(y[15:0]));
        rd(8'h90, m);
        rd(8'h08, 32'h000001FF);
        rnd = lfsr(rnd);
        bus(1'b1, 8'h00, {8'h6C, 5'd5, 5'd4, 1'b0, rnd[9:0], 3'd2});
        e = m + 32'(rnd[9:0]);
        rd(8'h94, e);
        bus(1'b1, 8'h00, {8'h65, 5'd6, 19'h7FFFD});
        bus(1'b1, 8'h00, {8'h4E, 5'd7, 5'd2, 5'd6, 4'h1, 2'd1, 3'h7});
        rd(8'h9C, x << 3);
        bus(1'b1, 8'h00, {8'h6A, 5'd9, 5'd2, 5'd0, 1'b0, 5'd1, 3'h7});
        bus(1'b1, 8'h00, {8'h6B, 5'd10, 5'd9, 6'd0, 5'd1, 3'h0});
        rd(8'hA8, x);
        bus(1'b1, 8'h00, {8'h6B, 5'd10, 5'd9, 6'd0, 5'd5, 3'h7});
        rd(8'hA8, x);
        rd(8'h14, 32'h00065505);
        rd(8'h04, 32'h0000086B);
        bus(1'b1, 8'h00, {8'h6B, 5'd11, 5'd2, 6'd0, 5'd13, 3'h7});
        rd(8'hAC, {24'h0, flags(e, m)});
        bus(1'b1, 8'h00, {8'h6A, 5'd12, 5'd3, 5'd0, 1'b0, 5'd18, 3'h7});
        bus(1'b1, 8'h00, {8'h6B, 5'd12, 5'd12, 6'd0, 5'd2, 3'h7});
        rd(8'hB0, y);
        rd(8'h08, {8'h00, flags(e, m), 8'h01, 8'h00});
        rd(8'hFC, 32'h0);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 16; i++) begin
            repeat (2) @(posedge clk);
            rnd = lfsr(rnd);
            vc[i % 4] <= rnd;
            @(posedge clk);
            md = 3'(i);
            ix = rnd[20:19];
            s2v_q.push_back({xf(md, i[3] ? vc[ix][31:16] : vc[ix][15:0],
                i[3] ? vc[ix | 2'd1][31:16] : vc[ix | 2'd1][15:0]),
                rnd[9], rnd[9:1], rnd[18], rnd[18:10]});
            bus(1'b1, 8'h00, {8'h24, md[1:0], i[3], ix, rnd[18:1], md[2]});
        end
        repeat (10) @(posedge clk);
        print_verdict;
    end
endmodule
